//--- design/cwb_fifo.v
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/100ps
module cwb_fifo #(
  parameter WIDTH = 68,
  parameter DEPTH = 4,
  parameter PTR_W = 2,
  parameter CNT_W = 3
) (
  // Clock and reset
  input                  core_clk,
  input                  rst_n,
  // Fill side
  input                  in_valid,
  output                 in_ready,
  input      [WIDTH-1:0] in_data,
  // Drain side
  output                 out_valid,
  input                  out_ready,
  output     [WIDTH-1:0] out_data,
  // Status
  output                 empty
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] rd_ptr_reg;
  reg [CNT_W-1:0] count_reg;
  wire            push;
  wire            pop;
  localparam [CNT_W-1:0] FULL_CNT = DEPTH;
  localparam [CNT_W-1:0] ONE_CNT  = 1;
  localparam [PTR_W-1:0] ONE_PTR  = 1;

  assign in_ready  = (count_reg != FULL_CNT);
  assign out_valid = (count_reg != {CNT_W{1'b0}});
  assign empty     = ~out_valid;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  always @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg  <= {CNT_W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + ONE_PTR;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + ONE_PTR;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + ONE_CNT;
      end else if (pop & ~push) begin
        count_reg <= count_reg - ONE_CNT;
      end
    end
  end
endmodule // cwb_fifo

//--- design/cwb_write_buffer.v
// Posted-write queue between processor core and memory interface
// What this block does
// - Pending stores sit in a four-entry FIFO holding address and data.
// - A memory load waits until every queued store has drained.
// - Uncached load stalls core until queue empty and load data returns.
// - Partial-word stores are never merged; each issues separately.
// - Stores are accepted while the queue has room; memory write completes later.
`timescale 1ns/100ps
`include "cwb_defines.vh"
module cwb_write_buffer (
  // Clock and reset
  input                         core_clk,
  input                         rst_n,
  // Core store request
  input                         st_valid,
  output                        st_ready,
  input      [`CWB_ADDR_W-1:0]  st_addr,
  input      [`CWB_DATA_W-1:0]  st_data,
  input      [`CWB_BE_W-1:0]    st_be,
  // Core load request (uncached or cache miss)
  input                         ld_valid,
  output                        ld_ready,
  input      [`CWB_ADDR_W-1:0]  ld_addr,
  output reg                    ld_done,
  output reg [`CWB_DATA_W-1:0]  ld_rdata,
  // Core stall and status
  output                        core_stall,
  output                        wb_empty,
  // Memory interface request
  output reg                    mem_req,
  output reg                    mem_we,
  output reg [`CWB_ADDR_W-1:0]  mem_addr,
  output reg [`CWB_DATA_W-1:0]  mem_wdata,
  output reg [`CWB_BE_W-1:0]    mem_be,
  input                         mem_ack,
  input      [`CWB_DATA_W-1:0]  mem_rdata
);
  // ==========================================================
  // Queue
  // ==========================================================
  wire                    q_in_ready;
  wire                    q_out_valid;
  wire                    q_out_ready;
  wire [`CWB_ENTRY_W-1:0] q_out_data;
  wire                    q_empty;

  cwb_fifo #(
    .WIDTH (`CWB_ENTRY_W),
    .DEPTH (`CWB_DEPTH),
    .PTR_W (`CWB_PTR_W),
    .CNT_W (`CWB_CNT_W)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (st_valid),
    .in_ready  (q_in_ready),
    .in_data   ({st_be, st_addr, st_data}),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out_data),
    .empty     (q_empty)
  );

  // Store taken without waiting for memory
  assign st_ready = q_in_ready;
  assign wb_empty = q_empty;

  // ==========================================================
  // Memory sequencer
  // ==========================================================
  reg [1:0] state_reg;
  reg [1:0] state_next;
  wire      ld_take;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Sequencer free to start a new memory operation
  function is_idle;
    input [1:0] st;
    begin
      is_idle = (st == `CWB_ST_IDLE);
    end
  endfunction

  // Byte enables of a queue entry
  function [`CWB_BE_W-1:0] entry_be;
    input [`CWB_ENTRY_W-1:0] entry;
    begin
      entry_be = entry[`CWB_ENTRY_W-1:`CWB_ENTRY_W-`CWB_BE_W];
    end
  endfunction

  // Address of a queue entry
  function [`CWB_ADDR_W-1:0] entry_addr;
    input [`CWB_ENTRY_W-1:0] entry;
    begin
      entry_addr = entry[`CWB_ADDR_W+`CWB_DATA_W-1:`CWB_DATA_W];
    end
  endfunction

  // Data of a queue entry
  function [`CWB_DATA_W-1:0] entry_data;
    input [`CWB_ENTRY_W-1:0] entry;
    begin
      entry_data = entry[`CWB_DATA_W-1:0];
    end
  endfunction

  // Loads only start once the queue is drained
  assign ld_take  = is_idle(state_reg) & ld_valid & q_empty;
  assign ld_ready = ld_take;
  // One entry popped per memory write, never combined
  assign q_out_ready = is_idle(state_reg) & q_out_valid;
  // Core waits on a pending load or a full queue
  assign core_stall = (ld_valid & ~ld_done) | (st_valid & ~q_in_ready);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `CWB_ST_IDLE: begin
        if (q_out_valid) begin
          state_next = `CWB_ST_WRITE;
        end else if (ld_valid) begin
          state_next = `CWB_ST_READ;
        end
      end
      `CWB_ST_WRITE: begin
        if (mem_ack) begin
          state_next = `CWB_ST_IDLE;
        end
      end
      `CWB_ST_READ: begin
        if (mem_ack) begin
          state_next = `CWB_ST_DONE;
        end
      end
      `CWB_ST_DONE: begin
        state_next = `CWB_ST_IDLE;
      end
      default: begin
        state_next = `CWB_ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `CWB_ST_IDLE;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= {`CWB_ADDR_W{1'b0}};
      mem_wdata <= {`CWB_DATA_W{1'b0}};
      mem_be    <= {`CWB_BE_W{1'b0}};
      ld_done   <= 1'b0;
      ld_rdata  <= {`CWB_DATA_W{1'b0}};
    end else begin
      state_reg <= state_next;
      ld_done   <= 1'b0;
      if (q_out_ready) begin
        mem_req   <= 1'b1;
        mem_we    <= 1'b1;
        mem_be    <= entry_be(q_out_data);
        mem_addr  <= entry_addr(q_out_data);
        mem_wdata <= entry_data(q_out_data);
      end else if (ld_take) begin
        mem_req  <= 1'b1;
        mem_we   <= 1'b0;
        mem_be   <= {`CWB_BE_W{1'b1}};
        mem_addr <= ld_addr;
      end else if (mem_ack) begin
        mem_req <= 1'b0;
        mem_we  <= 1'b0;
      end
      if ((state_reg == `CWB_ST_READ) & mem_ack) begin
        ld_rdata <= mem_rdata;
        ld_done  <= 1'b1;
      end
    end
  end
endmodule // cwb_write_buffer

//--- shared/cwb_defines.vh
// Constants for the posted-write queue
`ifndef CWB_DEFINES_VH
`define CWB_DEFINES_VH
`define CWB_ADDR_W     32
`define CWB_DATA_W     32
`define CWB_BE_W       4
`define CWB_ENTRY_W    68
`define CWB_DEPTH      4
`define CWB_PTR_W      2
`define CWB_CNT_W      3
`define CWB_ST_IDLE    2'h0
`define CWB_ST_WRITE   2'h1
`define CWB_ST_READ    2'h2
`define CWB_ST_DONE    2'h3
`endif

//--- verif/cwb_mem_model.sv
// Memory side model with settable latency
`timescale 1ns/100ps
module cwb_mem_model (
  // Clock, reset, latency
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [3:0]  lat,
  // Memory bus
  input  wire        mem_req,
  output reg         mem_ack,
  output reg  [31:0] mem_rdata
);
  reg  [3:0] cnt_reg;
  wire       hit = mem_req && !mem_ack && cnt_reg >= lat;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg   <= 4'h0;
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack   <= hit;
      cnt_reg   <= mem_req && !mem_ack ? cnt_reg + 4'h1 : 4'h0;
      // Changing pattern outside answers
      mem_rdata <= hit ? 32'hC0DE_5A5A : ~mem_rdata;
    end
  end
endmodule // cwb_mem_model

//--- verif/cwb_properties.sv
// Checker for the posted-write queue
`timescale 1ns/100ps
module cwb_props (
  input wire        core_clk, rst_n, st_valid, st_ready, ld_valid,
  input wire        ld_ready, ld_done, core_stall, wb_empty,
  input wire        mem_req, mem_we, mem_ack,
  input wire [31:0] mem_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_LD_EMPTY: assert property (
    ld_ready |-> wb_empty) else $error("load passed stores");
  AST_RD_DONE: assert property (
    mem_req && !mem_we && mem_ack |=> ld_done) else $error("no load done");
  AST_STALL: assert property (
    core_stall == (ld_valid && !ld_done || st_valid && !st_ready))
    else $error("stall wrong");
  AST_ONE_OP: assert property (
    mem_req && mem_ack |=> !mem_req) else $error("request ran on");
  AST_HOLD: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request dropped");
  AST_POST: assert property (
    st_valid && st_ready |=> !wb_empty) else $error("store lost");
  AST_DRAIN: assert property (
    !wb_empty && !mem_req && !ld_done |=> mem_req && mem_we)
    else $error("no drain");
  AST_FULL: assert property (
    !st_ready |-> !wb_empty && (mem_req || $past(mem_req) || $past(ld_done)))
    else $error("false refusal");
  cover property (st_valid && !st_ready);
  cover property (ld_done);
  cover property (mem_req && mem_we && mem_ack);
endmodule // cwb_props

bind cwb_write_buffer cwb_props i_props (.core_clk, .rst_n, .st_valid,
  .st_ready, .ld_valid, .ld_ready, .ld_done, .core_stall, .wb_empty,
  .mem_req, .mem_we, .mem_ack, .mem_addr);

//--- verif/testbench.sv
// Bench for the posted-write queue
`timescale 1ns/100ps
module testbench;
  logic        core_clk = 0, rst_n = 0, st_valid = 0, ld_valid = 0;
  logic [31:0] st_addr = 0, st_data = 0, ld_addr = 0;
  logic [3:0]  st_be = 0, lat = 4'h6;
  wire         st_ready, ld_ready, ld_done, core_stall, wb_empty;
  wire         mem_req, mem_ack, mem_we;
  wire  [31:0] ld_rdata, mem_addr, mem_wdata, mem_rdata;
  wire  [3:0]  mem_be;
  integer      fails = 0, check_count = 0, n, i, rd_at = 0;
  logic        stl = 0;
  logic [67:0] wlog [$];
  logic [67:0] rows [6] = '{68'h1_0000_0040_1111_1111,
    68'h1_0000_0080_0000_00AA, 68'h2_0000_0080_0000_BB00,
    68'hF_0000_00C0_3333_3333, 68'h8_0000_0100_4400_0000,
    68'hF_0000_0140_5555_5555};
  always #12.5 core_clk = ~core_clk;
  cwb_write_buffer i_dut (.core_clk, .rst_n, .st_valid, .st_ready,
    .st_addr, .st_data, .st_be, .ld_valid, .ld_ready, .ld_addr, .ld_done,
    .ld_rdata, .core_stall, .wb_empty, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_be, .mem_ack, .mem_rdata);
  cwb_mem_model i_mem (.core_clk, .rst_n, .lat, .mem_req, .mem_ack,
    .mem_rdata);
  always @(posedge core_clk) begin
    if (mem_req && mem_ack && mem_we)
      wlog.push_back({mem_be, mem_addr, mem_wdata});
    if (mem_req && !mem_we && rd_at == 0)
      rd_at = wlog.size() + 1;
  end
  task final_report;
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [67:0] s, input [67:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("Error %0t: got %0h want %0h", $time, s, e);
    end
  endtask
  task put(input [67:0] e);
    {st_be, st_addr, st_data} <= e;
    st_valid <= 1;
    #1;
    for (n = 0; n < 60 && st_ready !== 1'b1; n++) @(posedge core_clk) #1;
    stl |= n > 0;
    if (n == 60) begin
      fails++;
      final_report;
    end
    @(posedge core_clk);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    chk({st_ready, wb_empty, ld_ready, mem_req}, 4'hC);
    rst_n <= 1;
    for (i = 0; i < 6; i++) put(rows[i]);
    st_valid <= 0;
    lat <= 0;
    chk(wlog.size() < 6 && wb_empty === 1'b0, 1);
    chk(stl, 1);
    ld_addr <= 32'h200;
    ld_valid <= 1;
    #1;
    chk(core_stall, 1);
    for (n = 0; n < 200 && ld_done !== 1'b1; n++) @(posedge core_clk) #1;
    if (n == 200) begin
      fails++;
      final_report;
    end
    chk(rd_at, 7);
    chk({ld_rdata, core_stall}, {32'hC0DE_5A5A, 1'b0});
    @(posedge core_clk);
    ld_valid <= 0;
    for (i = 0; i < 6; i++) chk(wlog[i], rows[i]);
    final_report;
  end
endmodule // testbench
